// [shared/uspc_pkg.sv]
// Shared constants and state codes for the serial port control block.
package uspc_pkg;
  localparam logic [7:0] SCON_ADDR = 8'h98;
  localparam logic [7:0] SBUF_ADDR = 8'h99;
  localparam logic [7:0] SCON_RESET = 8'h40;
  localparam logic [7:0] SCON_FIXED = 8'h40;
  localparam logic [4:0] SCON_BIT_BASE = 5'h13;
  localparam int MODE_BIT = 7;
  localparam int MCE_BIT = 5;
  localparam int REN_BIT = 4;
  localparam int TB8_BIT = 3;
  localparam int RB8_BIT = 2;
  localparam int TI_BIT = 1;
  localparam int RI_BIT = 0;
  localparam logic [3:0] DATA_BITS = 4'h8;
  localparam logic [7:0] TIMER_TOP = 8'hff;

  typedef enum logic [4:0] {
    TX_IDLE = 5'h01,
    TX_START = 5'h02,
    TX_DATA = 5'h04,
    TX_NINTH = 5'h08,
    TX_STOP = 5'h10
  } uspc_tx_state_t;

  typedef enum logic [4:0] {
    RX_IDLE = 5'h01,
    RX_START = 5'h02,
    RX_DATA = 5'h04,
    RX_NINTH = 5'h08,
    RX_STOP = 5'h10
  } uspc_rx_state_t;
endpackage

// [rtl/uspc_baud_gen.sv]
// Baud tick generation from the external timer, with the receive timer copy.
`timescale 1ns/10ps
module uspc_baud_gen (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic timer_tick_in,
  input wire logic [7:0] baud_timer_reload_in,
  input wire logic tx_overflow_in,
  input wire logic rx_restart_in,
  output logic rx_overflow_out,
  output logic tx_bit_tick_out
);
  import uspc_pkg::*;

  typedef struct packed {
    logic [7:0] rx_cnt;
    logic rx_ovf;
    logic tx_half;
    logic tx_tick;
  } uspc_baud_t;

  uspc_baud_t s_ff;
  uspc_baud_t nxt_s;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.rx_ovf = 1'b0;
    nxt_s.tx_tick = 1'b0;
    if (rx_restart_in) begin
      nxt_s.rx_cnt = baud_timer_reload_in;
    end else if (timer_tick_in) begin
      if (s_ff.rx_cnt == TIMER_TOP) begin
        nxt_s.rx_cnt = baud_timer_reload_in;
        nxt_s.rx_ovf = 1'b1;
      end else begin
        nxt_s.rx_cnt = s_ff.rx_cnt + 8'h01;
      end
    end
    if (tx_overflow_in) begin
      nxt_s.tx_half = ~s_ff.tx_half;
      nxt_s.tx_tick = s_ff.tx_half;
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign rx_overflow_out = s_ff.rx_ovf;
  assign tx_bit_tick_out = s_ff.tx_tick;
endmodule

// [rtl/uspc_serial_port.sv]
// Serial port control register, framing and flag logic.
`timescale 1ns/10ps
module uspc_serial_port (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic [7:0] bit_addr_in,
  input wire logic bit_wr_in,
  input wire logic bit_wdata_in,
  input wire logic irq_enable_in,
  input wire logic timer_tick_in,
  input wire logic [7:0] baud_timer_reload_in,
  input wire logic tx_overflow_in,
  input wire logic serial_receive_pin_in,
  output logic [7:0] sfr_rdata_out,
  output logic serial_transmit_pin_out,
  output logic irq_out
);
  import uspc_pkg::*;

  typedef struct packed {
    logic [7:0] scon;
    logic [7:0] rx_buf;
    logic [7:0] rdata;
    logic irq;
    logic tx_pin;
    uspc_tx_state_t tx_state;
    logic [7:0] tx_sh;
    logic [3:0] tx_cnt;
    uspc_rx_state_t rx_state;
    logic [7:0] rx_sh;
    logic rx_ninth;
    logic [3:0] rx_cnt;
    logic rx_half;
    logic rx_prev;
  } uspc_state_t;

  uspc_state_t s_ff;
  uspc_state_t nxt_s;
  logic rx_ovf;
  logic tx_tick;
  logic rx_restart;
  logic scon_byte_wr;
  logic scon_bit_wr;
  logic sbuf_wr;
  logic rx_stop_sample;
  logic rx_qual;
  logic rx_accept;
  logic ti_set;
  logic [7:0] sw_scon;

  uspc_baud_gen u_baud (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .timer_tick_in(timer_tick_in),
    .baud_timer_reload_in(baud_timer_reload_in),
    .tx_overflow_in(tx_overflow_in),
    .rx_restart_in(rx_restart),
    .rx_overflow_out(rx_ovf),
    .tx_bit_tick_out(tx_tick)
  );

  assign scon_byte_wr = sfr_wr_in && (sfr_addr_in == SCON_ADDR);
  assign scon_bit_wr = bit_wr_in && (bit_addr_in[7:3] == SCON_BIT_BASE);
  assign sbuf_wr = sfr_wr_in && (sfr_addr_in == SBUF_ADDR);
  assign rx_restart = (s_ff.rx_state == RX_IDLE) && s_ff.scon[REN_BIT] && s_ff.rx_prev
                      && !serial_receive_pin_in;
  assign rx_stop_sample = (s_ff.rx_state == RX_STOP) && rx_ovf && s_ff.rx_half;
  assign rx_qual = s_ff.scon[MODE_BIT] ? s_ff.rx_ninth : serial_receive_pin_in;
  assign rx_accept = rx_stop_sample && !s_ff.scon[RI_BIT]
                     && (!s_ff.scon[MCE_BIT] || rx_qual);
  assign ti_set = (s_ff.tx_state == TX_STOP) && tx_tick && (s_ff.tx_cnt == 4'h0);

  always_comb begin
    sw_scon = s_ff.scon;
    if (scon_byte_wr) begin
      sw_scon = sfr_wdata_in;
    end else if (scon_bit_wr) begin
      sw_scon[bit_addr_in[2:0]] = bit_wdata_in;
    end
    sw_scon = sw_scon | SCON_FIXED;
  end

  always_comb begin
    nxt_s = s_ff;
    // hardware set wins over software clear.
    nxt_s.scon = sw_scon;
    nxt_s.scon[TI_BIT] = sw_scon[TI_BIT] | ti_set;
    nxt_s.scon[RI_BIT] = sw_scon[RI_BIT] | rx_accept;
    if (rx_accept) begin
      nxt_s.scon[RB8_BIT] = s_ff.scon[MODE_BIT] ? s_ff.rx_ninth : serial_receive_pin_in;
      nxt_s.rx_buf = s_ff.rx_sh;
    end
    nxt_s.irq = irq_enable_in && (nxt_s.scon[TI_BIT] || nxt_s.scon[RI_BIT]);
    nxt_s.rdata = s_ff.rdata;
    if (sfr_rd_in) begin
      if (sfr_addr_in == SCON_ADDR) begin
        nxt_s.rdata = s_ff.scon | SCON_FIXED;
      end else if (sfr_addr_in == SBUF_ADDR) begin
        nxt_s.rdata = s_ff.rx_buf;
      end else begin
        nxt_s.rdata = 8'h00;
      end
    end
    nxt_s.rx_prev = serial_receive_pin_in;
    unique case (s_ff.tx_state)
      TX_IDLE: begin
        if (sbuf_wr) begin
          nxt_s.tx_sh = sfr_wdata_in;
          nxt_s.tx_state = TX_START;
        end
      end
      TX_START: begin
        if (tx_tick) begin
          nxt_s.tx_pin = 1'b0;
          nxt_s.tx_cnt = 4'h0;
          nxt_s.tx_state = TX_DATA;
        end
      end
      TX_DATA: begin
        if (tx_tick) begin
          nxt_s.tx_pin = s_ff.tx_sh[0];
          nxt_s.tx_sh = {1'b0, s_ff.tx_sh[7:1]};
          nxt_s.tx_cnt = s_ff.tx_cnt + 4'h1;
          if (s_ff.tx_cnt == DATA_BITS - 4'h1) begin
            nxt_s.tx_state = s_ff.scon[MODE_BIT] ? TX_NINTH : TX_STOP;
            nxt_s.tx_cnt = 4'h0;
          end
        end
      end
      TX_NINTH: begin
        if (tx_tick) begin
          nxt_s.tx_pin = s_ff.scon[TB8_BIT];
          nxt_s.tx_state = TX_STOP;
        end
      end
      TX_STOP: begin
        if (tx_tick) begin
          nxt_s.tx_pin = 1'b1;
          nxt_s.tx_cnt = s_ff.tx_cnt + 4'h1;
          if (s_ff.tx_cnt != 4'h0) begin
            nxt_s.tx_state = TX_IDLE;
          end
        end
      end
    endcase
    unique case (s_ff.rx_state)
      RX_IDLE: begin
        if (rx_restart) begin
          nxt_s.rx_state = RX_START;
        end
      end
      RX_START: begin
        if (rx_ovf) begin
          nxt_s.rx_half = 1'b0;
          nxt_s.rx_cnt = 4'h0;
          nxt_s.rx_state = serial_receive_pin_in ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (rx_ovf) begin
          nxt_s.rx_half = ~s_ff.rx_half;
          if (s_ff.rx_half) begin
            nxt_s.rx_sh = {serial_receive_pin_in, s_ff.rx_sh[7:1]};
            nxt_s.rx_cnt = s_ff.rx_cnt + 4'h1;
            if (s_ff.rx_cnt == DATA_BITS - 4'h1) begin
              nxt_s.rx_state = s_ff.scon[MODE_BIT] ? RX_NINTH : RX_STOP;
            end
          end
        end
      end
      RX_NINTH: begin
        if (rx_ovf) begin
          nxt_s.rx_half = ~s_ff.rx_half;
          if (s_ff.rx_half) begin
            nxt_s.rx_ninth = serial_receive_pin_in;
            nxt_s.rx_state = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (rx_ovf) begin
          nxt_s.rx_half = ~s_ff.rx_half;
          if (s_ff.rx_half) begin
            nxt_s.rx_state = RX_IDLE;
          end
        end
      end
    endcase
    if (!s_ff.scon[REN_BIT]) begin
      nxt_s.rx_state = RX_IDLE;
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_ff <= '{scon: SCON_RESET, rx_buf: 8'h00, rdata: 8'h00, irq: 1'b0, tx_pin: 1'b1,
                tx_state: TX_IDLE, tx_sh: 8'h00, tx_cnt: 4'h0, rx_state: RX_IDLE,
                rx_sh: 8'h00, rx_ninth: 1'b0, rx_cnt: 4'h0, rx_half: 1'b0, rx_prev: 1'b1};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign sfr_rdata_out = s_ff.rdata;
  assign serial_transmit_pin_out = s_ff.tx_pin;
  assign irq_out = s_ff.irq;

  a_fixed_bit_read: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (sfr_rd_in && sfr_addr_in == SCON_ADDR) |=> sfr_rdata_out[6])
    else $error("Unused control bit did not read one.");
  a_stop_check_8: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (rx_stop_sample && !s_ff.scon[MODE_BIT] && s_ff.scon[MCE_BIT] && !serial_receive_pin_in
     && !s_ff.scon[RI_BIT] && !sw_scon[RI_BIT]) |=> !s_ff.scon[RI_BIT])
    else $error("Frame with low stop bit was accepted.");
  a_ninth_check_9: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (rx_stop_sample && s_ff.scon[MODE_BIT] && s_ff.scon[MCE_BIT] && !s_ff.rx_ninth
     && !sw_scon[RI_BIT]) |=> !s_ff.scon[RI_BIT])
    else $error("Frame with low ninth bit was accepted.");
  a_rx_disabled: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    !s_ff.scon[REN_BIT] |=> s_ff.rx_state == RX_IDLE)
    else $error("Receiver left idle while disabled.");
  a_ninth_tx_bit: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (s_ff.tx_state == TX_NINTH && tx_tick) |=>
      serial_transmit_pin_out == $past(s_ff.scon[TB8_BIT]))
    else $error("Ninth transmit bit not driven.");
  a_rb8_capture: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (rx_accept && !scon_byte_wr && !scon_bit_wr) |=>
      s_ff.scon[RB8_BIT] == ($past(s_ff.scon[MODE_BIT]) ? $past(s_ff.rx_ninth)
                                                         : $past(serial_receive_pin_in)))
    else $error("Ninth receive bit capture wrong.");
  a_ti_at_stop: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (!$past(s_ff.scon[TI_BIT]) && s_ff.scon[TI_BIT] && !$past(scon_byte_wr)
     && !$past(scon_bit_wr)) |-> (s_ff.tx_state == TX_STOP && serial_transmit_pin_out))
    else $error("Transmit flag set outside stop bit start.");
  a_ri_on_accept: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    rx_accept |=> s_ff.scon[RI_BIT] ##1 (s_ff.scon[RI_BIT] || $past(scon_byte_wr || scon_bit_wr)))
    else $error("Receive flag not set on accepted frame.");
  a_flags_sticky: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (s_ff.scon[TI_BIT] && !scon_byte_wr && !scon_bit_wr) |=> s_ff.scon[TI_BIT])
    else $error("Transmit flag cleared by hardware.");
  a_irq_follows: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (irq_enable_in && s_ff.scon[RI_BIT] && !scon_byte_wr && !scon_bit_wr) |=> irq_out)
    else $error("Interrupt request missing.");
  a_overrun_hold: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (rx_stop_sample && s_ff.scon[RI_BIT]) |=> $stable(s_ff.rx_buf))
    else $error("Receive latch overwritten while flag set.");
  a_start_bit_low: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (s_ff.tx_state == TX_START && tx_tick) |=> !serial_transmit_pin_out)
    else $error("Start bit not driven low.");
endmodule

// [sim/uspc_remote_node.sv]
// Remote serial node model that sends frames and captures transmitted ones.
`timescale 1ns/10ps
module uspc_remote_node (
  input wire logic sys_clk_in,
  input wire logic tx_line_in,
  input wire logic nine_in,
  output logic rx_line_out
);
  localparam int BIT_CYC = 16;
  logic [7:0] got_data = 8'h00;
  logic got_ninth = 1'b0;
  int got_cnt = 0;
  initial rx_line_out = 1'b1;
  task automatic send(input logic [7:0] d, input logic nine, input logic nb, input logic sb);
    logic [10:0] f;
    f = nine ? {sb, nb, d, 1'b0} : {1'b1, sb, d, 1'b0};
    for (int i = 0; i < (nine ? 11 : 10); i++) begin
      @(posedge sys_clk_in);
      rx_line_out <= f[i];
      repeat (BIT_CYC - 1) @(posedge sys_clk_in);
    end
    @(posedge sys_clk_in);
    rx_line_out <= 1'b1;
  endtask
  always begin
    @(negedge tx_line_in);
    repeat (BIT_CYC / 2) @(posedge sys_clk_in);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT_CYC) @(posedge sys_clk_in);
      if (i < 8) got_data[i] = tx_line_in;
      else if (nine_in) got_ninth = tx_line_in;
    end
    got_cnt++;
  end
endmodule

// [sim/uspc_serial_port_tb.sv]
// Self-checking bench for the serial port control block.
`timescale 1ns/10ps
module uspc_serial_port_tb;
  import uspc_pkg::*;
  logic clk, rstn, wr, rd, bwr, bwd, ien, ov, nine, txp, rxp, irq;
  logic [7:0] addr, wd, baddr, rdat, c, d, e, v, last;
  logic [31:0] seed = 32'h6b7f;
  logic [9:0] rxc [9] = '{10'h041, 10'h040, 10'h0c0, 10'h0c1, 10'h241, 10'h2c1, 10'h2c3,
    10'h001, 10'h054};
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;
  int n;
  uspc_serial_port uut (.sys_clk_in(clk), .resetn_in(rstn), .sfr_addr_in(addr),
    .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_wdata_in(wd), .bit_addr_in(baddr),
    .bit_wr_in(bwr), .bit_wdata_in(bwd), .irq_enable_in(ien), .timer_tick_in(1'b1),
    .baud_timer_reload_in(8'hf8), .tx_overflow_in(ov), .serial_receive_pin_in(rxp),
    .sfr_rdata_out(rdat), .serial_transmit_pin_out(txp), .irq_out(irq));
  uspc_remote_node rmt (.sys_clk_in(clk), .tx_line_in(txp), .nine_in(nine),
    .rx_line_out(rxp));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic acc(input logic [7:0] k, input logic nb, input logic sb);
    return k[4] & ~k[0] & (~k[5] | (k[7] ? nb : sb));
  endfunction
  function automatic logic [7:0] rx_exp(input logic [7:0] k, input logic nb, input logic sb);
    if (!acc(k, nb, sb)) return k | 8'h40;
    return (k & 8'hfb) | 8'h41 | {5'h0, (k[7] ? nb : sb), 2'h0};
  endfunction
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] x);
    checks++;
    if (s !== x) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic wr_t(input logic [7:0] a, input logic [7:0] x);
    @(negedge clk);
    addr = a;
    wd = x;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic bw_t(input logic [2:0] b, input logic x);
    @(negedge clk);
    baddr = SCON_ADDR + {5'h0, b};
    bwd = x;
    bwr = 1'b1;
    @(negedge clk);
    bwr = 1'b0;
  endtask
  task automatic rd_t(input logic [7:0] a, output logic [7:0] x);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
    x = rdat;
  endtask
  task automatic end_sim;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(negedge clk) begin
    cyc++;
    ov = (cyc % 8 == 0);
    if (cyc == 10000) begin
      error_cnt++;
      end_sim;
    end
  end
  initial begin
    {rstn, wr, rd, bwr, bwd, ien, nine} = 7'h00;
    {addr, wd, baddr} = 24'h0;
    last = 8'h00;
    repeat (6) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    rd_t(SCON_ADDR, v);
    chk("ctrl_reset", v, SCON_RESET);
    wr_t(SCON_ADDR, 8'hbf);
    ien = 1'b1;
    rd_t(SCON_ADDR, v);
    chk("ctrl_all", v, 8'hff);
    chk("irq_sw", {7'h0, irq}, 8'h01);
    wr_t(8'h9a, 8'h00);
    rd_t(SCON_ADDR, v);
    chk("ctrl_unmap", v, 8'hff);
    rd_t(8'h9a, v);
    chk("unmap_rd", v, 8'h00);
    wr_t(SCON_ADDR, 8'h00);
    e = 8'h40;
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      ien = seed[9];
      bw_t(seed[2:0], seed[8]);
      if (seed[2:0] != 3'h6) e[seed[2:0]] = seed[8];
      rd_t(SCON_ADDR, v);
      chk("ctrl_bit", v, e);
      chk("irq_bit", {7'h0, irq}, {7'h0, seed[9] & (e[1] | e[0])});
    end
    for (int m = 0; m < 3; m++) begin
      c = (m == 0) ? 8'h08 : ((m == 1) ? 8'h88 : 8'h80);
      nine = c[7];
      ien = 1'b0;
      n = rmt.got_cnt;
      seed = lfsr(seed);
      d = seed[7:0];
      wr_t(SCON_ADDR, c);
      wr_t(SBUF_ADDR, d);
      wr_t(SBUF_ADDR, ~d);
      for (int k = 0; k < 400 && rmt.got_cnt == n; k++) @(posedge clk);
      repeat (8) @(posedge clk);
      rd_t(SCON_ADDR, v);
      chk("tx_done", v, c | 8'h42);
      chk("tx_data", rmt.got_data, d);
      if (nine) chk("tx_ninth", {7'h0, rmt.got_ninth}, {7'h0, c[3]});
      ien = 1'b1;
      repeat (200) @(posedge clk);
      rd_t(SCON_ADDR, v);
      chk("tx_hold", v, c | 8'h42);
      chk("tx_irq", {7'h0, irq}, 8'h01);
      chk("tx_once", 8'(rmt.got_cnt - n), 8'h01);
      bw_t(3'(TI_BIT), 1'b0);
      rd_t(SCON_ADDR, v);
      chk("tx_irq_clr", {7'h0, irq}, 8'h00);
    end
    foreach (rxc[i]) begin
      c = rxc[i][9:2];
      nine = c[7];
      seed = lfsr(seed);
      d = seed[7:0];
      wr_t(SCON_ADDR, c);
      rmt.send(d, nine, rxc[i][1], rxc[i][0]);
      repeat (20) @(posedge clk);
      if (acc(c, rxc[i][1], rxc[i][0])) last = d;
      rd_t(SCON_ADDR, v);
      chk("rx_ctrl", v, rx_exp(c, rxc[i][1], rxc[i][0]));
      chk("rx_irq", {7'h0, irq}, {7'h0, v[0]});
      rd_t(SBUF_ADDR, v);
      chk("rx_data", v, last);
    end
    end_sim;
  end
endmodule
